/* fepd_core.sv */
// Erase, deep-sleep and wake/ID command handling of a serial flash.
// Assumes SPI pins asynchronous to i_clk, sampled at least 4x per SCK phase;
// the array itself sits outside and erases on o_erase.req.
//
// Contract
// - Block erase sets the addressed block to ones
// - Erase needs write enable latch set first
// - Block erase only if select rises after 32
// - Erase runs self-timed; busy flag; latch cleared
// - Protected block is never erased
// - Chip erase opcodes set whole array ones
// - Chip erase only if select rises after 8
// - Chip erase self-timed; busy flag; latch cleared
// - Chip erase ignored if any block protected
// - Deep sleep only via its opcode; blocks writes
// - Deselect gives standby only when not busy
// - In sleep only wake or reset obeyed
// - Power-up always lands in standby
// - Sleep command framed at 8; entry delayed
// - Sleep command rejected during busy cycles
// - Wake-only frame resumes after first delay
// - ID read repeats device ID MSB first
// - Wake from sleep after ID uses second delay
// - ID returned whether asleep or not
// - Wake/ID not decoded during busy cycles
// - Protection uses all protect bits and boot lock
`timescale 1ns/1ns
`default_nettype none

module fepd_core import fepd_pkg::*; #(
  parameter int unsigned P_BE_CYC = BE_CYC_DEF,
  parameter int unsigned P_CE_CYC = CE_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sck,
  input wire logic i_spi_serial_input,
  input wire fepd_protect_t i_protect,
  output logic o_spi_so,
  output logic o_spi_so_oe,
  output logic o_write_in_progress,
  output logic o_write_enable_latch,
  output logic o_deep_sleep,
  output logic o_standby,
  output fepd_erase_t o_erase
);

  ////////////////////////////////////////////////////////////////////////////
  // Protection evaluation

  // Count of blocks covered by the level bits, before complement
  function automatic logic [6:0] fepd_span(input fepd_protect_t p);
    logic [2:0] lvl;
    logic [6:0] n;
    lvl = {p.protect_level_bit2, p.protect_level_bit1, p.protect_level_bit0};
    n = 7'h00;
    if (lvl == 3'h0) begin
      n = 7'h00;
    end else if (p.small_granule_lock) begin
      n = 7'h01; // Sector-grain area lies inside the edge block
    end else if (lvl == 3'h7) begin
      n = BLOCK_COUNT;
    end else begin
      n = 7'(7'h01 << (lvl - 3'h1));
    end
    return n;
  endfunction

  // One block protected or not
  function automatic logic fepd_blk_prot(input fepd_protect_t p, input logic [5:0] blk);
    logic [6:0] n;
    logic in_rng;
    n = fepd_span(p);
    if (p.top_bottom_select) begin
      in_rng = ({1'b0, blk} < n);
    end else begin
      in_rng = ({1'b0, blk} >= 7'(BLOCK_COUNT - n));
    end
    return (in_rng ^ p.protect_complement) | (p.boot_lock & (blk == 6'h00));
  endfunction

  // Any block protected; complement of a full span leaves none
  function automatic logic fepd_any_prot(input fepd_protect_t p);
    logic [6:0] n;
    n = fepd_span(p);
    return p.boot_lock | (p.protect_complement ? (n != BLOCK_COUNT) : (n != 7'h00));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  fepd_state_t q;
  fepd_state_t d;
  logic cs_fall, cs_rise, sck_rise, sck_fall, id_phase, busy;

  // Edges are taken only from the second and third sync stages
  assign cs_fall = q.cs_p & ~q.cs_s;
  assign cs_rise = ~q.cs_p & q.cs_s;
  assign sck_rise = ~q.sck_p & q.sck_s & ~q.cs_s;
  assign sck_fall = q.sck_p & ~q.sck_s & ~q.cs_s;
  assign busy = (q.mode == FEPD_ERASE);
  assign id_phase = ~q.cs_s & (q.op == OP_WAKE_ID) & (q.cnt >= ADDR_FRAME_BITS) & ~busy;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    d = q;
    d.erase.req = 1'b0;
    // Two-flop synchronisers plus an edge-detect stage for select and clock
    d.cs_m = i_spi_cs_n;
    d.cs_s = q.cs_m;
    d.cs_p = q.cs_s;
    d.sck_m = i_spi_sck;
    d.sck_s = q.sck_m;
    d.sck_p = q.sck_s;
    d.si_m = i_spi_serial_input;
    d.si_s = q.si_m;

    // Frame start clears the bit counters and the opcode
    if (cs_fall) begin
      d.cnt = 6'h00;
      d.idx = 3'h0;
      d.op = 8'h00;
    end

    // Rising SCK shifts in; counter saturates so overlong frames never wrap to an exact length
    if (sck_rise) begin
      d.shift = {q.shift[30:0], q.si_s};
      d.idx = q.idx + 3'h1;
      if (q.cnt != BIT_COUNT_MAX) begin
        d.cnt = q.cnt + 6'h01;
      end
      if (q.cnt == OPCODE_BITS - 6'h01) begin
        d.op = {q.shift[6:0], q.si_s};
      end
    end

    // Falling SCK drives the ID, wrapping every eight bits
    if (sck_fall && id_phase) begin
      d.so = DEVICE_ID[3'h7 - q.idx];
      d.so_oe = 1'b1;
    end

    // Self-timed sequencing
    case (q.mode)
      FEPD_IDLE: begin
        d.timer = 32'h0000_0000;
      end
      FEPD_ERASE: begin
        if (q.timer == 32'h0000_0000) begin
          d.mode = FEPD_IDLE;
          d.write_in_progress = 1'b0;
        end else begin
          d.timer = q.timer - 32'h0000_0001;
        end
      end
      FEPD_SLEEP_ENTRY: begin
        if (q.timer == 32'h0000_0000) begin
          d.mode = FEPD_SLEEP;
        end else begin
          d.timer = q.timer - 32'h0000_0001;
        end
      end
      FEPD_SLEEP: begin
        d.timer = 32'h0000_0000;
      end
      FEPD_WAKE: begin
        if (q.timer == 32'h0000_0000) begin
          d.mode = FEPD_IDLE;
        end else begin
          d.timer = q.timer - 32'h0000_0001;
        end
      end
      default: begin
        d.mode = FEPD_IDLE;
      end
    endcase

    // Decode on deselect; only exact frame lengths count, except wake/ID in sleep, which takes 32 bits or more
    if (cs_rise) begin
      d.so_oe = 1'b0;
      if (q.mode == FEPD_IDLE) begin
        if (q.op == OP_WRITE_ENABLE && q.cnt == OPCODE_BITS) begin
          d.write_enable_latch = 1'b1;
        end else if (q.op == OP_BLOCK_ERASE && q.cnt == ADDR_FRAME_BITS && q.write_enable_latch
                     && !fepd_blk_prot(i_protect, q.shift[BLOCK_ADDR_LSB +: 6])) begin
          d.mode = FEPD_ERASE;
          d.timer = 32'(P_BE_CYC) - 32'h0000_0001;
          d.write_in_progress = 1'b1;
          d.write_enable_latch = 1'b0;
          d.erase = '{req: 1'b1, chip: 1'b0, block: q.shift[BLOCK_ADDR_LSB +: 6]};
        end else if ((q.op == OP_CHIP_ERASE_A || q.op == OP_CHIP_ERASE_B) && q.cnt == OPCODE_BITS
                     && q.write_enable_latch && !fepd_any_prot(i_protect)) begin
          d.mode = FEPD_ERASE;
          d.timer = 32'(P_CE_CYC) - 32'h0000_0001;
          d.write_in_progress = 1'b1;
          d.write_enable_latch = 1'b0;
          d.erase = '{req: 1'b1, chip: 1'b1, block: 6'h00};
        end else if (q.op == OP_DEEP_SLEEP && q.cnt == OPCODE_BITS) begin
          d.mode = FEPD_SLEEP_ENTRY;
          d.timer = 32'(SLEEP_CYC) - 32'h0000_0001;
        end
      end else if (q.mode == FEPD_SLEEP) begin
        // Everything else is dropped, writes included
        if (q.op == OP_WAKE_ID && q.cnt == OPCODE_BITS) begin
          d.mode = FEPD_WAKE;
          d.timer = 32'(RES1_CYC) - 32'h0000_0001;
        end else if (q.op == OP_WAKE_ID && q.cnt >= ADDR_FRAME_BITS) begin
          d.mode = FEPD_WAKE;
          d.timer = 32'(RES2_CYC) - 32'h0000_0001;
        end else if (q.op == OP_SOFT_RESET && q.cnt == OPCODE_BITS) begin
          d.mode = FEPD_IDLE;
        end
      end
      // Busy cycles ignore sleep and wake/ID; the erase runs on untouched
    end

    // Registered status views
    d.sleep = (d.mode == FEPD_SLEEP);
    d.standby = q.cs_s & (d.mode == FEPD_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset stands for power-up, which always ends in standby

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_spi_so = q.so;
  assign o_spi_so_oe = q.so_oe;
  assign o_write_in_progress = q.write_in_progress;
  assign o_write_enable_latch = q.write_enable_latch;
  assign o_deep_sleep = q.sleep;
  assign o_standby = q.standby;
  assign o_erase = q.erase;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Block erase only from an exact 32-bit frame
  be_frame_a: assert property (q.erase.req && !q.erase.chip |->
    q.cnt == ADDR_FRAME_BITS && q.op == OP_BLOCK_ERASE)
    else $error("block erase from a bad frame");

  // Chip erase only from an exact 8-bit frame
  ce_frame_a: assert property (q.erase.req && q.erase.chip |->
    q.cnt == OPCODE_BITS && (q.op == OP_CHIP_ERASE_A || q.op == OP_CHIP_ERASE_B))
    else $error("chip erase from a bad frame");

  // Erase start shows busy and a cleared latch, having had the latch
  erase_start_a: assert property (q.erase.req |->
    q.write_in_progress && !q.write_enable_latch && $past(q.write_enable_latch))
    else $error("erase start without latch or busy");

  // Protected block never erased
  blk_prot_a: assert property (q.erase.req && !q.erase.chip |->
    !fepd_blk_prot($past(i_protect), q.erase.block))
    else $error("protected block erased");

  // Chip erase never with a protected block
  chip_prot_a: assert property (q.erase.req && q.erase.chip |-> !fepd_any_prot($past(i_protect)))
    else $error("chip erase with protection on");

  // Sleep lets no erase through
  sleep_quiet_a: assert property (q.mode == FEPD_SLEEP |=> !q.erase.req)
    else $error("erase started in deep sleep");

  // Busy cycle only ends in idle
  busy_keep_a: assert property (busy |=> q.mode == FEPD_ERASE ||
    (q.mode == FEPD_IDLE && !q.write_in_progress))
    else $error("busy cycle disturbed");

  // No ID output while busy
  id_quiet_a: assert property (busy |-> ##1 !q.so_oe || $past(q.so_oe))
    else $error("ID driven during busy cycle");

  // Sleep entry only after the entry delay
  sleep_entry_a: assert property ($rose(q.sleep) |-> $past(q.mode, 30) == FEPD_SLEEP_ENTRY)
    else $error("sleep entered too early");

  // Wake completes within the longer wake delay
  wake_done_a: assert property ($rose(q.mode == FEPD_WAKE) |-> ##[1:31] q.mode == FEPD_IDLE)
    else $error("wake took too long");

  // Write enable frame sets the latch
  latch_set_a: assert property (cs_rise && q.mode == FEPD_IDLE && q.cnt == OPCODE_BITS &&
    q.op == OP_WRITE_ENABLE |=> q.write_enable_latch)
    else $error("write enable frame lost");

  // No erase starts without the latch
  no_latch_a: assert property (cs_rise && !q.write_enable_latch |=> !q.erase.req)
    else $error("erase started without write enable");

  // Erase starts only on a deselect
  erase_cs_a: assert property (q.erase.req |-> $past(cs_rise))
    else $error("erase started inside a frame");

  // Busy ends in idle with the latch cleared
  erase_end_a: assert property ($fell(q.write_in_progress) |->
    q.mode == FEPD_IDLE && !q.write_enable_latch)
    else $error("erase ended in a wrong state");

  // Standby only while idle and not busy
  standby_idle_a: assert property (q.standby |-> q.mode == FEPD_IDLE && !q.write_in_progress)
    else $error("standby during an internal cycle");

  // Deep sleep obeys no write enable
  sleep_latch_a: assert property (q.mode == FEPD_SLEEP && !q.write_enable_latch |=> !q.write_enable_latch)
    else $error("latch set in deep sleep");

  // Sleep is left only by a decoded command
  sleep_exit_a: assert property ($fell(q.sleep) |-> $past(cs_rise) &&
    (q.mode == FEPD_WAKE || q.mode == FEPD_IDLE))
    else $error("sleep left without a command");

  // Busy cycle never heads into sleep
  busy_awake_a: assert property (busy |=> !q.sleep && q.mode != FEPD_SLEEP_ENTRY)
    else $error("sleep entry during busy cycle");

  // ID byte starts with its top bit
  id_first_a: assert property (sck_fall && id_phase && q.idx == 3'h0 |=>
    q.so_oe && q.so == DEVICE_ID[7])
    else $error("ID bit out of order");

  // Deselect releases the output
  oe_drop_a: assert property (cs_rise |=> !q.so_oe)
    else $error("output driven after deselect");

  wake_c: cover property ($rose(q.mode == FEPD_WAKE));
  be_start_c: cover property (q.erase.req && !q.erase.chip);
  ce_start_c: cover property (q.erase.req && q.erase.chip);
  sleep_c: cover property ($rose(q.sleep));
  id_out_c: cover property (q.so_oe && q.mode == FEPD_SLEEP);

endmodule // fepd_core

`default_nettype wire

/* fepd_host.sv */
// Host SPI master model for the erase and deep-sleep command block.
// Assumes one system clock; each SCK phase lasts four clock cycles (800 ns SCK).
`timescale 1ns/1ns
`default_nettype none

module fepd_host (
  input wire logic i_clk,
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle pins; mode 0 clock stands low between frames
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifts n bits MSB first from d; select stays low for the whole frame
  task automatic frame(input logic [47:0] d, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int b = 0; b < n; b++) begin
      o_si <= d[47 - b];
      o_sck <= 1'b0;
      repeat (4) @(posedge i_clk);
      rx = {rx[14:0], i_so}; // Output has settled since the falling edge
      o_sck <= 1'b1;
      repeat (4) @(posedge i_clk);
    end
    o_sck <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1; // Rises right after the last bit
    o_si <= ~o_si; // Released line must not show a stale bit
    repeat (4) @(posedge i_clk);
  endtask
endmodule // fepd_host

`default_nettype wire

/* fepd_pkg.sv */
// Package for the erase and power-down command block of the serial flash.
// Assumes one system clock of 10 MHz; the SPI pins are asynchronous to it.
`default_nettype none

package fepd_pkg;

  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;

  // Device ID; the value is arbitrary
  localparam logic [7:0] DEVICE_ID = 8'h5a;

  // Frame lengths in serial clocks, bit counter limit, block count and block address LSB
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] ADDR_FRAME_BITS = 6'h20;
  localparam logic [5:0] BIT_COUNT_MAX = 6'h3f;
  localparam logic [6:0] BLOCK_COUNT = 7'h40;
  localparam int BLOCK_ADDR_LSB = 16;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_SLEEP_NS = 3000;
  localparam int T_RES1_NS = 3000;
  localparam int T_RES2_NS = 1800;
  localparam int T_BE_US = 1000;
  localparam int T_CE_US = 4000;
  localparam int SLEEP_CYC = (T_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RES1_CYC = (T_RES1_NS / CLK_PERIOD_NS < 1) ? 1 : T_RES1_NS / CLK_PERIOD_NS;
  localparam int RES2_CYC = (T_RES2_NS / CLK_PERIOD_NS < 1) ? 1 : T_RES2_NS / CLK_PERIOD_NS;
  localparam int BE_CYC_DEF = T_BE_US * 1000 / CLK_PERIOD_NS;
  localparam int CE_CYC_DEF = T_CE_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    FEPD_IDLE = 3'h0,
    FEPD_SLEEP_ENTRY = 3'h1,
    FEPD_SLEEP = 3'h3,
    FEPD_WAKE = 3'h2,
    FEPD_ERASE = 3'h4
  } fepd_mode_t;

  typedef struct packed {
    logic protect_complement;
    logic small_granule_lock;
    logic top_bottom_select;
    logic protect_level_bit2;
    logic protect_level_bit1;
    logic protect_level_bit0;
    logic boot_lock;
  } fepd_protect_t;

  typedef struct packed {
    logic req;
    logic chip;
    logic [5:0] block;
  } fepd_erase_t;

  typedef struct packed {
    logic cs_m, cs_s, cs_p;
    logic sck_m, sck_s, sck_p;
    logic si_m, si_s;
    logic [5:0] cnt;
    logic [2:0] idx;
    logic [31:0] shift;
    logic [7:0] op;
    fepd_mode_t mode;
    logic [31:0] timer;
    logic write_enable_latch;
    logic write_in_progress;
    logic sleep;
    logic standby;
    logic so;
    logic so_oe;
    fepd_erase_t erase;
  } fepd_state_t;

  localparam fepd_state_t STATE_RESET = '{
    cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1, sck_m: 1'b0, sck_s: 1'b0, sck_p: 1'b0,
    si_m: 1'b0, si_s: 1'b0, cnt: 6'h00, idx: 3'h0, shift: 32'h0000_0000, op: 8'h00,
    mode: FEPD_IDLE, timer: 32'h0000_0000, write_enable_latch: 1'b0,
    write_in_progress: 1'b0, sleep: 1'b0, standby: 1'b1, so: 1'b0, so_oe: 1'b0,
    erase: '{req: 1'b0, chip: 1'b0, block: 6'h00}};

endpackage

`default_nettype wire

/* placeholder_unused.sv */
// Intentionally empty companion file; holds no logic.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the erase and deep-sleep command block.
// Assumes the host model drives the serial pins; erase timers are shortened.
`timescale 1ns/1ns
`default_nettype none

module tb_top import fepd_pkg::*; ;
  localparam int BE_CYC = 2000;
  localparam int CE_CYC = 400;
  logic clk, rst, cs_n, sck, si, so, so_oe, in_prog, wr_latch, deep, stby;
  fepd_protect_t prot;
  fepd_erase_t erase, last;
  logic [15:0] rx, oe_base;
  logic [15:0] req_cnt = 16'h0000; // Only the monitor below writes these
  logic [15:0] oe_cnt = 16'h0000;
  int mismatches, n_checks;

  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  fepd_core #(.P_BE_CYC(BE_CYC), .P_CE_CYC(CE_CYC)) i_dut (
    .i_clk(clk), .i_rst(rst), .i_spi_cs_n(cs_n), .i_spi_sck(sck), .i_spi_serial_input(si),
    .i_protect(prot), .o_spi_so(so), .o_spi_so_oe(so_oe), .o_write_in_progress(in_prog),
    .o_write_enable_latch(wr_latch), .o_deep_sleep(deep), .o_standby(stby), .o_erase(erase)
  );

  fepd_host i_host (.i_clk(clk), .i_so(so), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

  // Counts erase pulses and notes any drive of the output pin
  always @(posedge clk) begin
    if (erase.req === 1'b1) begin
      req_cnt <= req_cnt + 16'h0001;
      last <= erase;
    end
    if (so_oe === 1'b1) begin
      oe_cnt <= oe_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Extra cycles let the select rise cross the synchroniser
  task automatic send(input logic [47:0] d, input int n);
    i_host.frame(d, n, rx);
    cycles(4);
  endtask

  task automatic write_enable_cmd;
    send({OP_WRITE_ENABLE, 40'h0}, 8);
  endtask

  task automatic blk(input logic [23:0] a, input int n);
    send({OP_BLOCK_ERASE, a, 16'h0000}, n);
  endtask

  task automatic sleep;
    send({OP_DEEP_SLEEP, 40'h0}, 8);
    cycles(40);
  endtask

  // Polls the busy flag under a bound before the next write
  task automatic wait_idle;
    int k;
    k = 0;
    while (in_prog !== 1'b0 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (k == 5000) begin
      mismatches++;
      print_verdict;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; a refused frame must leave every flag untouched
  initial begin
    rst = 1'b1;
    prot = '0;
    mismatches = 0;
    n_checks = 0;
    cycles(4);
    rst <= 1'b0;
    cycles(4);
    check({12'h000, in_prog, wr_latch, deep, stby}, 16'h0001);
    blk(24'h05_1234, 32);
    check(req_cnt, 16'h0000);
    write_enable_cmd;
    check({15'h0, wr_latch}, 16'h0001);
    blk(24'h05_1234, 31);
    blk(24'h05_1234, 33);
    check(req_cnt, 16'h0000);
    prot.boot_lock <= 1'b1;
    blk(24'h00_8000, 32);
    check(req_cnt, 16'h0000);
    prot <= 7'h0e;
    blk(24'h20_0000, 32);
    send({OP_CHIP_ERASE_A, 40'h0}, 8);
    check(req_cnt, 16'h0000);
    prot <= '0;
    blk(24'h05_1234, 32);
    check({8'h00, last}, 16'h0085);
    check({13'h0000, in_prog, wr_latch, stby}, 16'h0004);
    oe_base = oe_cnt;
    send({OP_DEEP_SLEEP, 40'h0}, 8);
    send({OP_WAKE_ID, 40'h0}, 48);
    check({14'h0000, deep, in_prog}, 16'h0001);
    check(oe_cnt, oe_base);
    wait_idle;
    check({14'h0000, wr_latch, stby}, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      write_enable_cmd;
      send({(i == 0) ? OP_CHIP_ERASE_A : OP_CHIP_ERASE_B, 40'h0}, 9);
      check(req_cnt, 16'(i + 1));
      send({(i == 0) ? OP_CHIP_ERASE_A : OP_CHIP_ERASE_B, 40'h0}, 8);
      check({13'h0000, last.chip, in_prog, wr_latch}, 16'h0006);
      wait_idle;
    end
    check(req_cnt, 16'h0003);
    send({OP_DEEP_SLEEP, 40'h0}, 9);
    cycles(40);
    check({15'h0, deep}, 16'h0000);
    write_enable_cmd;
    send({OP_DEEP_SLEEP, 40'h0}, 8);
    check({15'h0, deep}, 16'h0000);
    cycles(40);
    check({14'h0, deep, stby}, 16'h0002);
    blk(24'h05_1234, 32);
    cycles(20);
    check(req_cnt, 16'h0003);
    send({OP_WAKE_ID, 40'h0}, 48);
    check(rx, {DEVICE_ID, DEVICE_ID});
    check({14'h0, deep, stby}, 16'h0000);
    cycles(24);
    check({15'h0, stby}, 16'h0001);
    sleep;
    send({OP_WAKE_ID, 40'h0}, 8);
    check({14'h0, deep, stby}, 16'h0000);
    cycles(40);
    check({15'h0, stby}, 16'h0001);
    oe_base = oe_cnt;
    send({OP_WAKE_ID, 40'h0}, 48);
    check(rx, {DEVICE_ID, DEVICE_ID});
    check({15'h0, oe_cnt != oe_base}, 16'h0001);
    sleep;
    send({OP_SOFT_RESET, 40'h0}, 8);
    check({15'h0, deep}, 16'h0000);
    cycles(40);
    sleep;
    rst <= 1'b1;
    cycles(2);
    rst <= 1'b0;
    cycles(4);
    check({12'h000, in_prog, wr_latch, deep, stby}, 16'h0001);
    print_verdict;
  end
endmodule // tb_top

`default_nettype wire
